// File: shared/bsp_pkg.sv
/*
  shared constants, field positions and carrier types of the branch,
  stack and predictor sequencer block.
  assumes a single 20 MHz core clock and a synchronous active-low reset.
*/
`default_nettype none
package bsp_pkg;
  // return-address stack
  localparam int BSP_AW = 32;
  localparam int BSP_RS_DEPTH = 30;
  localparam logic [4:0] BSP_RS_FULL = 5'h1e;
  localparam logic [4:0] BSP_RS_IRQ_LVL = 5'h1d;
  localparam logic [4:0] BSP_RS_OVF = 5'h1f;
  localparam logic [31:0] BSP_RS_EMPTY_VAL = 32'h7fffffff;
  localparam int BSP_PTR_WR_LAT = 1; // cycles before a pointer write lands
  // status stack
  localparam int BSP_SS_DEPTH = 15;
  localparam logic [3:0] BSP_SS_FULL = 4'hf;
  // sticky status fields
  localparam int BSP_PCFL_BIT = 21;
  localparam int BSP_PCEM_BIT = 22;
  localparam int BSP_STATUS_STACK_OVERFLOW_BIT = 23;
  localparam int BSP_STATUS_STACK_EMPTY_BIT = 24;
  // predictor geometry and timing
  localparam int BSP_WAYS = 2;
  localparam int BSP_SETS = 128;
  localparam int BSP_IDXW = 7;
  localparam int BSP_TAGW = BSP_AW - BSP_IDXW;
  localparam int BSP_PRED_LAT = 2; // cycles from fetch to predicted target
  // predictor_config fields
  localparam int BSP_CFG_EN = 0;   // 1 = predictor on
  localparam int BSP_CFG_FRZ = 1;  // 1 = contents frozen
  localparam int BSP_CFG_LOCK = 2; // 1 = lock range active
  localparam int BSP_CFG_RETP = 3; // 1 = returns use return_stack_top
  // register offsets
  localparam logic [7:0] BSP_OFS_RS_TOP = 8'h00;
  localparam logic [7:0] BSP_OFS_RS_PTR = 8'h04;
  localparam logic [7:0] BSP_OFS_STICKY = 8'h08;
  localparam logic [7:0] BSP_OFS_MODE = 8'h0c;
  localparam logic [7:0] BSP_OFS_MASK = 8'h10;
  localparam logic [7:0] BSP_OFS_ASTX = 8'h14;
  localparam logic [7:0] BSP_OFS_ASTY = 8'h18;
  localparam logic [7:0] BSP_OFS_SMODE = 8'h1c;
  localparam logic [7:0] BSP_OFS_CFG = 8'h20;
  localparam logic [7:0] BSP_OFS_LK_S = 8'h24;
  localparam logic [7:0] BSP_OFS_LK_E = 8'h28;
  // reset values
  localparam logic [3:0] BSP_RST_CFG = 4'h9;
  localparam logic [31:0] BSP_RST_MODE = 32'h0;
  localparam logic [31:0] BSP_RST_MASK = 32'h0;
  localparam logic [31:0] BSP_RST_LK = 32'h0;

  // branch kind seen at the final stage
  typedef enum logic [5:0] {
    BSP_BR_JUMP = 6'h01,
    BSP_BR_CALL = 6'h02,
    BSP_BR_RTS = 6'h04,
    BSP_BR_RTI = 6'h08,
    BSP_BR_CI = 6'h10,
    BSP_BR_LOOP = 6'h20
  } bsp_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bsp_bus_t;

  // stack events from decode/execute and the interrupt controller
  typedef struct packed {
    logic call;
    logic [31:0] call_next; // address after the call
    logic rts;
    logic interrupt_return;
    logic [5:0] rti_idx;
    logic jump_ci;
    logic irq_entry;
    logic irq_nosave;       // emulator or reset interrupt
    logic [31:0] irq_ret;
    logic push_pc;
    logic [31:0] push_pc_val;
    logic pop_pc;
    logic push_sts;
    logic pop_sts;
  } bsp_evt_t;

  // branch resolved at the final stage
  typedef struct packed {
    logic valid;
    bsp_kind_t kind;
    logic cond;
    logic taken;
    logic pred_hit;
    logic pred_taken;
    logic [31:0] pc;
    logic [31:0] target;
    logic [31:0] next;
  } bsp_res_t;

  // unconditional target check at the address stage
  typedef struct packed {
    logic valid;
    logic pred_hit;
    logic [31:0] pred_target;
    logic [31:0] target;
  } bsp_chk_t;

  typedef struct packed {
    logic hit;
    logic taken;
    logic is_ret;
    logic [31:0] target;
  } bsp_look_t;

  typedef struct packed {
    logic valid;
    logic taken;
    logic is_ret;
    logic lock;
    logic [31:0] pc;
    logic [31:0] target;
  } bsp_upd_t;

  typedef struct packed {
    logic flush_all;   // whole pipeline
    logic flush_front; // first_fetch_stage .. second_decode_stage
    logic [31:0] addr;
  } bsp_redir_t;

  typedef struct packed {
    logic valid;
    logic [5:0] idx;
  } bsp_iclr_t;

  typedef struct packed {
    logic [31:0] astx;
    logic [31:0] asty;
    logic [31:0] mode;
  } bsp_ss_ent_t;

  typedef struct packed {
    logic [BSP_WAYS-1:0][BSP_SETS-1:0] vld;
    logic [BSP_WAYS-1:0][BSP_SETS-1:0] lck;
    logic [BSP_WAYS-1:0][BSP_SETS-1:0] ret;
    logic [BSP_SETS-1:0] lru; // way to replace next
    logic [BSP_WAYS-1:0][BSP_SETS-1:0][1:0] ctr;
    logic [BSP_WAYS-1:0][BSP_SETS-1:0][BSP_TAGW-1:0] tag;
    logic [BSP_WAYS-1:0][BSP_SETS-1:0][31:0] tgt;
  } bsp_btb_st_t;

  typedef struct packed {
    logic [BSP_RS_DEPTH-1:0][31:0] rs;
    logic [4:0] ptr;
    logic pw_pend;
    logic [4:0] pw_val;
    bsp_ss_ent_t [BSP_SS_DEPTH-1:0] ss;
    logic [3:0] ss_cnt;
    logic status_stack_overflow;
    logic [31:0] mode;
    logic [31:0] mask;
    logic [31:0] astx;
    logic [31:0] asty;
    logic [3:0] cfg;
    logic [31:0] lk_s;
    logic [31:0] lk_e;
    logic [31:0] rdata;
    logic p1_v;
    logic [31:0] p1_t;
    logic p2_v;
    logic [31:0] p2_t;
    bsp_redir_t redir;
    bsp_iclr_t iclr;
  } bsp_st_t;
endpackage
`default_nettype wire

// File: src/bsp_btb.sv
/*
  two-way branch target buffer with saturating counters, lru and lock.
  assumes the parent gates updates for disable, freeze and excluded kinds.
*/
`timescale 1ns/1ps
`default_nettype none
module bsp_btb (
  input wire logic clk,
  input wire logic nrst,
  input wire logic look_en,
  input wire logic [31:0] look_addr,
  output bsp_pkg::bsp_look_t look,
  input wire bsp_pkg::bsp_upd_t upd
);
  bsp_pkg::bsp_btb_st_t st; // whole buffer
  bsp_pkg::bsp_btb_st_t next_st;
  logic [1:0] lm; // lookup way match
  logic lw;
  logic [6:0] li;

  // way match of an address, shared by lookup and update
  function automatic logic [1:0] bsp_match(input bsp_pkg::bsp_btb_st_t s,
                                           input logic [31:0] a);
    logic [1:0] m;
    m = '0;
    for (int w = 0; w < bsp_pkg::BSP_WAYS; w++) begin
      m[w] = s.vld[w][a[6:0]] && (s.tag[w][a[6:0]] == a[31:7]);
    end
    return m;
  endfunction

  // every fetch address is looked up
  assign li = look_addr[6:0];
  assign lm = bsp_match(st, look_addr);
  assign lw = lm[1];
  assign look.hit = look_en && (|lm);
  assign look.taken = look.hit && st.ctr[lw][li][1];
  assign look.is_ret = look.hit && st.ret[lw][li];
  assign look.target = st.tgt[lw][li];

  // update at validation: counter on hit, allocation on miss
  always_comb begin
    logic [1:0] um;
    logic [6:0] ui;
    logic vw;
    logic [1:0] c;
    next_st = st;
    ui = upd.pc[6:0];
    um = bsp_match(st, upd.pc);
    vw = 1'b0;
    c = 2'h0;
    if (upd.valid) begin
      if (|um) begin
        vw = um[1];
        c = st.ctr[vw][ui];
        if (upd.taken && c != 2'h3) begin
          c = c + 2'h1;
        end else if (!upd.taken && c != 2'h0) begin
          c = c - 2'h1;
        end
        next_st.ctr[vw][ui] = c;
        next_st.lru[ui] = ~vw;
      end else begin
        // invalid way first, then least recently used
        if (!st.vld[0][ui]) begin
          vw = 1'b0;
        end else if (!st.vld[1][ui]) begin
          vw = 1'b1;
        end else begin
          vw = st.lru[ui];
        end
        if (st.vld[vw][ui] && st.lck[vw][ui]) begin
          vw = ~vw;
        end
        // both ways locked: the new branch is simply not recorded
        if (!(st.vld[vw][ui] && st.lck[vw][ui])) begin
          next_st.vld[vw][ui] = 1'b1;
          next_st.lck[vw][ui] = upd.lock;
          next_st.ret[vw][ui] = upd.is_ret;
          next_st.tag[vw][ui] = upd.pc[31:7];
          next_st.tgt[vw][ui] = upd.target;
          next_st.ctr[vw][ui] = upd.taken ? 2'h2 : 2'h1;
          next_st.lru[ui] = ~vw;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // bsp_btb
`default_nettype wire

// File: src/bsp_seq.sv
/*
  sequencer stacks and branch prediction control: return stack, status
  stack, flush and redirect decisions, predictor configuration registers.
  assumes decode/execute report stack events and resolved branches in the
  core clock domain, and a register port with read data one cycle later.
*/
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module bsp_seq (
  input wire logic clk,
  input wire logic nrst,
  input wire bsp_pkg::bsp_bus_t bus,
  output logic [31:0] reg_rdata,
  input wire bsp_pkg::bsp_evt_t evt,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire bsp_pkg::bsp_res_t res,
  input wire bsp_pkg::bsp_chk_t chk,
  output logic pred_valid,
  output logic [31:0] pred_target,
  output bsp_pkg::bsp_redir_t redirect,
  output logic [31:0] return_addr,
  output logic stack_overflow_irq,
  output bsp_pkg::bsp_iclr_t irq_clear,
  output bsp_pkg::bsp_ss_ent_t core_status
);
  bsp_pkg::bsp_st_t st; // all sequencer state
  bsp_pkg::bsp_st_t next_st;
  bsp_pkg::bsp_look_t look; // buffer lookup of this fetch
  bsp_pkg::bsp_upd_t upd; // buffer update of the resolved branch
  logic [31:0] top; // current return_stack_top view
  logic pred_en; // predictor enabled

  // top-entry view; an overflowed stack still shows its last stored slot
  function automatic logic [31:0] bsp_top(input bsp_pkg::bsp_st_t s);
    logic [4:0] i;
    i = (s.ptr == bsp_pkg::BSP_RS_OVF) ? (bsp_pkg::BSP_RS_FULL - 5'h1)
                                       : (s.ptr - 5'h1);
    return (s.ptr == 5'h0) ? bsp_pkg::BSP_RS_EMPTY_VAL : s.rs[i];
  endfunction

  assign top = bsp_top(st);
  assign pred_en = st.cfg[bsp_pkg::BSP_CFG_EN];

  // buffer: lookup every fetch while enabled
  bsp_btb u_btb (
    .clk(clk),
    .nrst(nrst),
    .look_en(fetch_valid && pred_en),
    .look_addr(fetch_addr),
    .look(look),
    .upd(upd)
  );

  // buffer update from the final stage
  always_comb begin
    logic excl;
    excl = (res.kind == bsp_pkg::BSP_BR_LOOP) || (res.kind == bsp_pkg::BSP_BR_RTI) ||
           (res.kind == bsp_pkg::BSP_BR_CI);
    upd.valid = res.valid && pred_en && !excl &&
                !st.cfg[bsp_pkg::BSP_CFG_FRZ];
    upd.taken = res.taken;
    upd.is_ret = (res.kind == bsp_pkg::BSP_BR_RTS);
    upd.lock = st.cfg[bsp_pkg::BSP_CFG_LOCK] && (res.pc >= st.lk_s) &&
               (res.pc <= st.lk_e);
    upd.pc = res.pc;
    upd.target = res.target;
  end

  // next-state logic of the whole block
  always_comb begin
    logic wr_top;
    logic rs_push;
    logic rs_pop;
    logic [31:0] push_val;
    logic [4:0] ti;
    logic ss_push;
    logic ss_pop;
    logic [3:0] si;
    logic [31:0] rv;
    logic mispred;
    logic bad_tgt;
    next_st = st;
    rv = '0;
    push_val = '0; // overwritten by the source chain below
    wr_top = bus.wr && (bus.addr == bsp_pkg::BSP_OFS_RS_TOP);
    rs_push = evt.call || evt.irq_entry || evt.push_pc;
    rs_pop = evt.rts || evt.interrupt_return || evt.pop_pc;
    // call address wins, then interrupt return address, then explicit
    if (evt.call) begin
      push_val = evt.call_next;
    end else if (evt.irq_entry) begin
      push_val = evt.irq_ret;
    end else begin
      push_val = evt.push_pc_val;
    end
    ti = (st.ptr == bsp_pkg::BSP_RS_OVF) ? (bsp_pkg::BSP_RS_FULL - 5'h1)
                                         : (st.ptr - 5'h1);

    // return stack: a landing pointer write overrides everything
    if (st.pw_pend) begin
      next_st.ptr = st.pw_val;
      next_st.pw_pend = 1'b0;
    end else if (wr_top) begin
      // write goes to the top slot, pointer untouched, push dropped
      if (st.ptr != 5'h0) begin
        next_st.rs[ti] = bus.wdata;
      end
    end else if (rs_push && !rs_pop) begin
      if (st.ptr < bsp_pkg::BSP_RS_FULL) begin
        next_st.rs[st.ptr] = push_val;
        next_st.ptr = st.ptr + 5'h1;
      end else begin
        next_st.ptr = bsp_pkg::BSP_RS_OVF;
      end
    end else if (rs_pop && !rs_push) begin
      // popping an overflowed stack drops the lost push and the top
      if (st.ptr == bsp_pkg::BSP_RS_OVF) begin
        next_st.ptr = bsp_pkg::BSP_RS_FULL - 5'h1;
      end else if (st.ptr != 5'h0) begin
        next_st.ptr = st.ptr - 5'h1;
      end
    end
    // push and pop together leave the stack as it is

    // pointer write: queued one cycle, refused while overflowed
    if (bus.wr && bus.addr == bsp_pkg::BSP_OFS_RS_PTR &&
        st.ptr != bsp_pkg::BSP_RS_OVF && !st.pw_pend) begin
      next_st.pw_pend = 1'b1;
      // only the n oldest survive; never grows past what is stored
      next_st.pw_val = (bus.wdata[4:0] < st.ptr) ? bus.wdata[4:0] : st.ptr;
    end

    // software writes to status, mode and predictor registers
    if (bus.wr) begin
      case (bus.addr)
        bsp_pkg::BSP_OFS_STICKY: next_st.status_stack_overflow = bus.wdata[bsp_pkg::BSP_STATUS_STACK_OVERFLOW_BIT];
        bsp_pkg::BSP_OFS_MODE: next_st.mode = bus.wdata;
        bsp_pkg::BSP_OFS_MASK: next_st.mask = bus.wdata;
        bsp_pkg::BSP_OFS_ASTX: next_st.astx = bus.wdata;
        bsp_pkg::BSP_OFS_ASTY: next_st.asty = bus.wdata;
        bsp_pkg::BSP_OFS_CFG: next_st.cfg = bus.wdata[3:0];
        bsp_pkg::BSP_OFS_LK_S: next_st.lk_s = bus.wdata;
        bsp_pkg::BSP_OFS_LK_E: next_st.lk_e = bus.wdata;
        default: next_st.cfg = next_st.cfg; // return-stack writes handled above, read-only or unmapped
      endcase
    end

    // status stack; hardware updates after software so set wins
    ss_push = (evt.irq_entry && !evt.irq_nosave) || evt.push_sts;
    ss_pop = evt.interrupt_return || evt.jump_ci || evt.pop_sts;
    si = st.ss_cnt - 4'h1;
    if (ss_push) begin
      if (st.ss_cnt == bsp_pkg::BSP_SS_FULL) begin
        next_st.status_stack_overflow = 1'b1;
      end else begin
        next_st.ss[st.ss_cnt] = '{astx: st.astx, asty: st.asty, mode: st.mode};
        next_st.ss_cnt = st.ss_cnt + 4'h1;
      end
      next_st.mode = st.mode & ~st.mask;
    end else if (ss_pop && st.ss_cnt != 4'h0) begin
      next_st.astx = st.ss[si].astx;
      next_st.asty = st.ss[si].asty;
      next_st.mode = st.ss[si].mode;
      next_st.ss_cnt = si;
    end

    // serviced interrupt release toward the interrupt controller
    next_st.iclr.valid = evt.interrupt_return;
    next_st.iclr.idx = evt.rti_idx;

    // flush decisions: final stage first, address stage second
    mispred = res.valid && res.cond &&
              (res.taken != (res.pred_taken && pred_en));
    bad_tgt = chk.valid && (!chk.pred_hit || !pred_en ||
                            chk.pred_target != chk.target);
    next_st.redir.flush_all = mispred;
    next_st.redir.flush_front = bad_tgt && !mispred;
    if (mispred) begin
      next_st.redir.addr = res.taken ? res.target : res.next;
    end else if (bad_tgt) begin
      next_st.redir.addr = chk.target;
    end

    // two-stage prediction pipe; delayed branches use the two slots
    next_st.p1_v = look.taken && !mispred && !bad_tgt;
    if (look.is_ret && st.cfg[bsp_pkg::BSP_CFG_RETP]) begin
      next_st.p1_t = top;
    end else begin
      next_st.p1_t = look.target;
    end
    next_st.p2_v = st.p1_v && !mispred && !bad_tgt;
    next_st.p2_t = st.p1_t;

    // register reads, answered in the next cycle only
    if (bus.rd) begin
      case (bus.addr)
        bsp_pkg::BSP_OFS_RS_TOP: rv = top;
        bsp_pkg::BSP_OFS_RS_PTR: rv = {27'h0, st.ptr};
        bsp_pkg::BSP_OFS_STICKY: begin
          rv[bsp_pkg::BSP_PCFL_BIT] = (st.ptr >= bsp_pkg::BSP_RS_FULL);
          rv[bsp_pkg::BSP_PCEM_BIT] = (st.ptr == 5'h0);
          rv[bsp_pkg::BSP_STATUS_STACK_OVERFLOW_BIT] = st.status_stack_overflow;
          rv[bsp_pkg::BSP_STATUS_STACK_EMPTY_BIT] = (st.ss_cnt == 4'h0);
        end
        bsp_pkg::BSP_OFS_MODE: rv = st.mode;
        bsp_pkg::BSP_OFS_MASK: rv = st.mask;
        bsp_pkg::BSP_OFS_ASTX: rv = st.astx;
        bsp_pkg::BSP_OFS_ASTY: rv = st.asty;
        bsp_pkg::BSP_OFS_SMODE: rv = (st.ss_cnt == 4'h0) ? 32'h0 : st.ss[si].mode;
        bsp_pkg::BSP_OFS_CFG: rv = {28'h0, st.cfg};
        bsp_pkg::BSP_OFS_LK_S: rv = st.lk_s;
        bsp_pkg::BSP_OFS_LK_E: rv = st.lk_e;
        default: rv = 32'h0; // unmapped reads zero
      endcase
    end
    next_st.rdata = rv;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.cfg <= bsp_pkg::BSP_RST_CFG;
      st.mode <= bsp_pkg::BSP_RST_MODE;
      st.mask <= bsp_pkg::BSP_RST_MASK;
      st.lk_s <= bsp_pkg::BSP_RST_LK;
      st.lk_e <= bsp_pkg::BSP_RST_LK;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign reg_rdata = st.rdata;
  assign pred_valid = st.p2_v;
  assign pred_target = st.p2_t;
  assign redirect = st.redir;
  assign return_addr = top;
  assign stack_overflow_irq = (st.ptr >= bsp_pkg::BSP_RS_IRQ_LVL);
  assign irq_clear = st.iclr;
  assign core_status = '{astx: st.astx, asty: st.asty, mode: st.mode};
endmodule // bsp_seq
`default_nettype wire

// File: test/bsp_seq_properties.sv
/*
  port-level checker for bsp_seq.
  assumes the design package and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module bsp_seq_props (
  input wire logic clk,
  input wire logic nrst,
  input wire bsp_pkg::bsp_bus_t bus,
  input wire logic [31:0] reg_rdata,
  input wire bsp_pkg::bsp_evt_t evt,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire bsp_pkg::bsp_res_t res,
  input wire bsp_pkg::bsp_chk_t chk,
  input wire logic pred_valid,
  input wire logic [31:0] pred_target,
  input wire bsp_pkg::bsp_redir_t redirect,
  input wire logic [31:0] return_addr,
  input wire logic stack_overflow_irq,
  input wire bsp_pkg::bsp_iclr_t irq_clear,
  input wire bsp_pkg::bsp_ss_ent_t core_status
);
  // one clock domain, so one default clock and reset
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // stack starts out empty
  property p_rst_empty;
    !$past(nrst) |-> return_addr == bsp_pkg::BSP_RS_EMPTY_VAL;
  endproperty
  a_rst_empty: assert property (p_rst_empty)
    else $error("top not empty after reset");
  // lone call shows its address on top; writes and other events excluded
  property p_call_push;
    evt.call && !(evt.rts || evt.interrupt_return || evt.irq_entry || evt.push_pc || evt.pop_pc)
      && !bus.wr && !$past(bus.wr) && !stack_overflow_irq
      |=> return_addr == $past(evt.call_next);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call address not on top");
  // near-full flag only rises after a push
  property p_ovf_rise;
    $rose(stack_overflow_irq) |-> $past(evt.call || evt.irq_entry || evt.push_pc);
  endproperty
  a_ovf_rise: assert property (p_ovf_rise)
    else $error("overflow flag without push");
  // clear pulse exactly one cycle after each interrupt return
  property p_iclr_v;
    $past(nrst) |-> irq_clear.valid == $past(evt.interrupt_return);
  endproperty
  a_iclr_v: assert property (p_iclr_v)
    else $error("clear pulse mistimed");
  property p_iclr_idx;
    evt.interrupt_return |=> irq_clear.idx == $past(evt.rti_idx);
  endproperty
  a_iclr_idx: assert property (p_iclr_idx)
    else $error("clear index wrong");
  // taken branch predicted not taken flushes everything toward target
  property p_flush_all;
    res.valid && res.cond && res.taken && !res.pred_taken
      |=> redirect.flush_all && redirect.addr == $past(res.target);
  endproperty
  a_flush_all: assert property (p_flush_all)
    else $error("missing full flush");
  // wrong or missing unconditional target flushes the front
  property p_flush_front;
    chk.valid && (!chk.pred_hit || chk.pred_target != chk.target)
      |=> redirect.flush_front || redirect.flush_all;
  endproperty
  a_flush_front: assert property (p_flush_front)
    else $error("missing front flush");
  // a prediction always answers a fetch two cycles back
  property p_pred_lat;
    pred_valid |-> $past(fetch_valid, 2);
  endproperty
  a_pred_lat: assert property (p_pred_lat)
    else $error("prediction without fetch");
endmodule // bsp_seq_props
bind bsp_seq bsp_seq_props u_props (.clk, .nrst, .bus, .reg_rdata, .evt, .fetch_valid,
  .fetch_addr, .res, .chk, .pred_valid, .pred_target, .redirect, .return_addr,
  .stack_overflow_irq, .irq_clear, .core_status);
`default_nettype wire

// File: test/bsp_core_model.sv
/*
  fetch unit and interrupt latch facing bsp_seq.
  assumes the bench steers fetch with load and raises latch bits.
*/
`timescale 1ns/1ps
`default_nettype none
module bsp_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [31:0] load_addr,
  input wire logic raise,
  input wire logic pred_valid,
  input wire logic [31:0] pred_target,
  input wire bsp_pkg::bsp_redir_t redirect,
  input wire bsp_pkg::bsp_iclr_t irq_clear,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic [63:0] latch
);
  // fetch: bench load first, then flush, then prediction, else sequential
  always @(posedge clk) begin
    fetch_valid <= nrst;
    if (!nrst) fetch_addr <= 32'h0;
    else if (load) fetch_addr <= load_addr;
    else if (redirect.flush_all || redirect.flush_front) fetch_addr <= redirect.addr;
    else if (pred_valid) fetch_addr <= pred_target;
    else fetch_addr <= fetch_addr + 32'h4;
  end
  // latch: raise reuses load_addr as index to save a port
  always @(posedge clk) begin
    if (!nrst) latch <= '0;
    else begin
      if (raise) latch[load_addr[5:0]] <= 1'b1;
      if (irq_clear.valid) latch[irq_clear.idx] <= 1'b0;
    end
  end
endmodule // bsp_core_model
`default_nettype wire

// File: test/testbench.sv
/*
  self-checking bench for bsp_seq.
  assumes the design package, the core model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bsp_pkg::bsp_bus_t bus = '0;
  bsp_pkg::bsp_evt_t evt = '0;
  bsp_pkg::bsp_res_t res = '0;
  bsp_pkg::bsp_chk_t chk = '0;
  logic load = 1'b0;
  logic [31:0] load_addr = 32'h0;
  logic raise = 1'b0;
  logic fetch_valid, pred_valid, stack_overflow_irq;
  logic [31:0] fetch_addr, reg_rdata, pred_target, return_addr;
  logic [63:0] latch;
  bsp_pkg::bsp_redir_t redirect;
  bsp_pkg::bsp_iclr_t irq_clear;
  bsp_pkg::bsp_ss_ent_t core_status;
  bsp_pkg::bsp_evt_t e;
  int miscompares = 0;
  int total_checks = 0;
  int i;
  // reset view: address, expected read
  logic [39:0] rows [8] = '{40'h00_7fffffff, 40'h04_00000000, 40'h08_01400000,
    40'h0c_00000000, 40'h10_00000000, 40'h20_00000009, 40'h24_00000000, 40'h30_00000000};
  bsp_seq uut (.clk, .nrst, .bus, .reg_rdata, .evt, .fetch_valid, .fetch_addr, .res, .chk,
    .pred_valid, .pred_target, .redirect, .return_addr, .stack_overflow_irq, .irq_clear,
    .core_status);
  bsp_core_model u_core (.clk, .nrst, .load, .load_addr, .raise, .pred_valid, .pred_target,
    .redirect, .irq_clear, .fetch_valid, .fetch_addr, .latch);
  initial forever #25 clk = ~clk;
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic ev(input bsp_pkg::bsp_evt_t x);
    @(posedge clk);
    evt <= x;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask
  task automatic call(input logic [31:0] a);
    bsp_pkg::bsp_evt_t x;
    x = '0;
    x.call = 1'b1;
    x.call_next = a;
    ev(x);
  endtask
  // conditional branch resolved at the last stage, target fixed at 8000
  task automatic rs(input logic t, input logic h, input logic pt, input logic [31:0] pc);
    @(posedge clk);
    res <= '{valid: 1'b1, kind: bsp_pkg::BSP_BR_JUMP, cond: 1'b1, taken: t, pred_hit: h,
      pred_taken: pt, pc: pc, target: 32'h8000, next: pc + 32'h4};
    @(posedge clk);
    res <= '0;
    #1 check({31'h0, redirect.flush_all}, {31'h0, t != pt});
    if (t != pt) check(redirect.addr, t ? 32'h8000 : pc + 32'h4);
  endtask
  // steer fetch to pc and watch the prediction window
  task automatic pr(input logic [31:0] pc, input logic hit);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    load <= 1'b1;
    load_addr <= pc;
    @(posedge clk);
    load <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1 if (pred_valid === 1'b1 && pred_target === 32'h8000) seen = 1'b1;
    end
    check({31'h0, seen}, {31'h0, hit});
  endtask
  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) rd(rows[i][39:32], rows[i][31:0]);
    wr(8'h00, 32'h55);
    rd(8'h00, 32'h7fffffff);
    rd(8'h04, 32'h0);
    for (i = 1; i < 4; i++) call(32'h1000 + i);
    rd(8'h04, 32'h3);
    check(return_addr, 32'h1003);
    wr(8'h00, 32'haaaa);
    rd(8'h04, 32'h3);
    check(return_addr, 32'haaaa);
    e = '0;
    e.call = 1'b1;
    e.call_next = 32'h2000;
    @(posedge clk);
    bus <= '{addr: 8'h00, wdata: 32'hbbbb, wr: 1'b1, rd: 1'b0};
    evt <= e;
    @(posedge clk);
    bus.wr <= 1'b0;
    evt <= '0;
    rd(8'h04, 32'h3);
    check(return_addr, 32'hbbbb);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h1);
    check(return_addr, 32'h1001);
    e = '0;
    e.rts = 1'b1;
    ev(e);
    check(return_addr, 32'h7fffffff);
    for (i = 1; i < 32; i++) begin
      call(i);
      if (i == 28 || i == 29) check({31'h0, stack_overflow_irq}, i - 28);
    end
    rd(8'h04, 32'h1f);
    wr(8'h04, 32'h2);
    rd(8'h04, 32'h1f);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wr(8'h0c, 32'hff);
    wr(8'h10, 32'h0f);
    @(posedge clk);
    raise <= 1'b1;
    load_addr <= 32'h5;
    @(posedge clk);
    raise <= 1'b0;
    e = '0;
    e.irq_entry = 1'b1;
    e.irq_ret = 32'h3000;
    ev(e);
    check(core_status.mode, 32'hf0);
    rd(8'h08, 32'h0);
    e.irq_nosave = 1'b1;
    e.irq_ret = 32'h3004;
    ev(e);
    rd(8'h1c, 32'hff);
    wr(8'h0c, 32'h3c);
    e = '0;
    e.interrupt_return = 1'b1;
    e.rti_idx = 6'h05;
    ev(e);
    check(core_status.mode, 32'hff);
    check(return_addr, 32'h3000);
    @(posedge clk);
    #1 check({31'h0, latch[5]}, 32'h0);
    e = '0;
    e.push_sts = 1'b1;
    ev(e);
    check(core_status.mode, 32'hf0);
    e = '0;
    e.jump_ci = 1'b1;
    ev(e);
    check(core_status.mode, 32'hff);
    e = '0;
    e.push_sts = 1'b1;
    for (i = 1; i < 17; i++) begin
      ev(e);
      if (i > 14) rd(8'h08, i == 16 ? 32'h800000 : 32'h0);
    end
    rs(1'b1, 1'b0, 1'b0, 32'h400000);
    pr(32'h400000, 1'b1);
    wr(8'h20, 32'h8);
    pr(32'h400000, 1'b0);
    wr(8'h20, 32'hb);
    pr(32'h400000, 1'b1);
    rs(1'b1, 1'b0, 1'b0, 32'h400100);
    pr(32'h400100, 1'b0);
    wr(8'h20, 32'h9);
    rs(1'b0, 1'b1, 1'b1, 32'h400000);
    pr(32'h400000, 1'b0);
    rs(1'b1, 1'b1, 1'b0, 32'h400000);
    pr(32'h400000, 1'b1);
    @(posedge clk);
    chk <= '{valid: 1'b1, pred_hit: 1'b1, pred_target: 32'h9000, target: 32'h8000};
    @(posedge clk);
    chk <= '0;
    #1 check({31'h0, redirect.flush_front}, 32'h1);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
